/* File: logic/pcn_pkg.sv */
// Shared constants, field layout and encodings of the protection config block.
// Assumes a single 50 MHz system clock on both ends.
package pcn_pkg;
  localparam int DATA_W = 16;
  localparam int MV_W = 14;
  localparam int CLK_KHZ = 50000;

  // Link command codes
  typedef enum logic [2:0] {
    PCN_OP_NOP = 3'b000,
    PCN_OP_CFG_WR = 3'b001,
    PCN_OP_CFG_RD = 3'b010,
    PCN_OP_CTL_WR = 3'b011,
    PCN_OP_STAT_RD = 3'b100,
    PCN_OP_WRITE_ENABLE_CMD = 3'b101,
    PCN_OP_ARRAY_WR = 3'b110,
    PCN_OP_CTL_RD = 3'b111
  } pcn_op_t;

  typedef enum logic [1:0] {
    PCN_SLEEP = 2'b00,
    PCN_NORMAL = 2'b01,
    PCN_STORE = 2'b10
  } pcn_dev_state_t;

  // Configuration field positions
  localparam int CFG_OV_LSB = 14;
  localparam int CFG_UV_LSB = 12;
  localparam int CFG_OC_LSB = 10;
  localparam int CFG_CE_LSB = 8;
  localparam int CFG_CELLS_BIT = 7;
  localparam int CFG_INHIBIT_OFF_BIT = 6;
  localparam logic [15:0] CFG_USED_MASK = 16'hFFC0;
  localparam logic [15:0] CFG_DEFAULT_4CELL = 16'h30C0;
  localparam logic [15:0] CFG_DEFAULT_3CELL = 16'h0040;

  // Control field positions
  localparam int CTL_SLEEP_BIT = 7;
  localparam int CTL_GAIN_LSB = 8;
  localparam int CTL_CHG_FET_BIT = 10;
  localparam int CTL_DSG_FET_BIT = 11;
  localparam int CTL_BAL_LSB = 12;
  localparam logic [15:0] CTL_USED_MASK = 16'hFF80;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // Status bit positions
  localparam int STAT_REG_OC_BIT = 0;
  localparam int STAT_UV_BIT = 1;
  localparam int STAT_CHG_BIT = 2;

  // Threshold tables in millivolts: base plus step per code; wake levels fixed per variant
  localparam int OV_BASE_MV = 4200;
  localparam int OV_STEP_MV = 50;
  localparam int UV_BASE_4CELL_MV = 1950;
  localparam int UV_BASE_3CELL_MV = 2250;
  localparam int UV_STEP_MV = 100;
  localparam int OC_BASE_MV = 75;
  localparam int OC_STEP_MV = 25;
  localparam int CE_BASE_MV = 500;
  localparam int CE_STEP_MV = 300;
  localparam int WAKE_4CELL_MV = 16000;
  localparam int WAKE_3CELL_MV = 12000;

  // Timing
  localparam int CAL_EXTRA_MS = 200;
  localparam int STORE_TIME_US = 10;
  localparam int STORE_CYCLES = (STORE_TIME_US * CLK_KHZ + 999) / 1000;

  // Host APB register offsets
  localparam logic [11:0] HOST_CMD_OFS = 12'h000;
  localparam logic [11:0] HOST_WDATA_OFS = 12'h004;
  localparam logic [11:0] HOST_RDATA_OFS = 12'h008;
  localparam logic [11:0] HOST_STATUS_OFS = 12'h00C;
  localparam logic [11:0] HOST_MUX_OFS = 12'h010;
  localparam int HST_BUSY_BIT = 0;
  localparam int HST_AWAKE_BIT = 1;
  localparam int HST_FET_OK_BIT = 2;
  localparam int HST_REFUSED_BIT = 3;
endpackage

/* File: logic/pcn_link_if.sv */
// Link between the pack controller (host) and the protection device.
// Host drives a held request; device answers with a one-cycle ack.
`timescale 1ns/10ps
interface pcn_link_if;
  logic deviceAwake;
  logic cmdValid;
  logic [2:0] cmdOp;
  logic [15:0] cmdData;
  logic [2:0] muxSel;
  logic cmdAck;
  logic [15:0] rspData;

  modport dev (
    input cmdValid,
    input cmdOp,
    input cmdData,
    input muxSel,
    output deviceAwake,
    output cmdAck,
    output rspData
  );

  modport host (
    output cmdValid,
    output cmdOp,
    output cmdData,
    output muxSel,
    input deviceAwake,
    input cmdAck,
    input rspData
  );
endinterface

/* File: logic/pcn_shadow_store.sv */
// Nonvolatile shadow of the configuration and its timed store cycle.
// Assumes factoryLoad is pulsed once at manufacture; sys_rst models power loss.
`timescale 1ns/10ps
module pcn_shadow_store #(
  parameter int W = 16,
  parameter int CYCLES = pcn_pkg::STORE_CYCLES,
  parameter logic [W-1:0] FACTORY = pcn_pkg::CFG_DEFAULT_4CELL
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic factoryLoad,
  input wire logic storeStart,
  input wire logic [W-1:0] storeData,
  output logic [W-1:0] shadowData,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 1) begin : g_bad
      $error("pcn_shadow_store: CYCLES must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] shadow;
    logic [W-1:0] pending;
    logic busy;
    logic [CW-1:0] cnt;
  } pcn_sh_st_t;

  pcn_sh_st_t s_reg;
  pcn_sh_st_t s_next;

  // Commit only at the end of the cycle; a power loss mid-cycle keeps the old copy
  always_comb begin
    s_next = s_reg;
    if (s_reg.busy) begin
      if (s_reg.cnt == CW'(CYCLES - 1)) begin
        s_next.shadow = s_reg.pending;
        s_next.busy = 1'b0;
      end else begin
        s_next.cnt = s_reg.cnt + CW'(1);
      end
    end else if (storeStart) begin
      s_next.pending = storeData;
      s_next.busy = 1'b1;
      s_next.cnt = '0;
    end
    if (factoryLoad) begin
      s_next.shadow = FACTORY;
    end
  end

  // Power loss aborts a store but never clears the shadow
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '{shadow: (factoryLoad ? FACTORY : s_reg.shadow), pending: '0, busy: 1'b0,
                 cnt: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign shadowData = s_reg.shadow;
  assign busy = s_reg.busy;
endmodule

/* File: logic/pcn_device.sv */
// Protection device end: configuration RAM with shadow recall and store,
// control bits, FET drive, status encoding and the sleep/normal sequencing.
// Assumes the host keeps one request held until ack and drops it next cycle.
//
// Functional notes
// - Start asleep, wake only on wake voltage
// - Host holds mux select and link low
// - Entering normal clears all control bits
// - Host delays FET turn-on past calibration interval
// - Sixteen-bit configuration field layout, low six ignored
// - Factory defaults per cell-count variant
// - Over-charge code selects 4.20V to 4.35V
// - Over-discharge code selects 0.1V steps per variant
// - Over-current code selects 0.075V to 0.150V
// - Inhibit-off bit zero enables low-cell blocking
// - Charge-enable code selects 0.5V to 1.40V
// - Cell-count one means four; three-cell keeps zero
// - Shadow copy recalled into register at power-up
// - Config write touches only volatile copy
// - Write-enable then array write stores shadow
// - Status bit 0 is untuned OR over-current
// - Status bit 2 depends on inhibit-off bit
// - Control bits 10 and 11 drive FETs
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module pcn_device #(
  parameter bit FOUR_CELL = 1'b1,
  parameter int STORE_CYCLES = pcn_pkg::STORE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic factoryLoad,
  input wire logic wakeDetect,
  input wire logic regulatorUntuned,
  input wire logic overcurrentActive,
  input wire logic overdischargeActive,
  input wire logic overchargeActive,
  input wire logic lowCell,
  pcn_link_if.dev link,
  output logic chargeFetOn,
  output logic dischargeFetOn,
  output logic [3:0] cellBalanceOn,
  output logic [1:0] senseGain,
  output logic [2:0] analogMuxSel,
  output logic fourCells,
  output logic lowCellInhibitEn,
  output logic [13:0] overchargeMv,
  output logic [13:0] undervoltageMv,
  output logic [13:0] overcurrentMv,
  output logic [13:0] chargeEnableMv,
  output logic [13:0] wakeThresholdMv,
  output logic [15:0] configValue
);
  localparam logic [15:0] CFG_FACTORY =
    FOUR_CELL ? pcn_pkg::CFG_DEFAULT_4CELL : pcn_pkg::CFG_DEFAULT_3CELL;
  localparam int UV_BASE =
    FOUR_CELL ? pcn_pkg::UV_BASE_4CELL_MV : pcn_pkg::UV_BASE_3CELL_MV;
  localparam int WAKE_MV = FOUR_CELL ? pcn_pkg::WAKE_4CELL_MV : pcn_pkg::WAKE_3CELL_MV;

  generate
    if (STORE_CYCLES < 1) begin : g_bad
      $error("pcn_device: STORE_CYCLES must be at least 1");
    end
  endgenerate

  typedef struct packed {
    pcn_pkg::pcn_dev_state_t state;
    logic [15:0] cfg;
    logic [15:0] ctrl;
    logic write_enable_cmd;
    logic storeGo;
    logic ack;
    logic [15:0] rsp;
    logic [2:0] mux;
  } pcn_dev_st_t;

  pcn_dev_st_t s_reg;
  pcn_dev_st_t s_next;
  logic [15:0] shadowData;
  logic storeBusy;
  logic [2:0] statusBits;

  // Two-bit field of the configuration at a given position
  function automatic logic [1:0] cfgField(input logic [15:0] cfg, input int lsb);
    cfgField = cfg[lsb +: 2];
  endfunction

  // Linear threshold table: base plus step times code
  function automatic logic [13:0] thrMv(input int base, input int step, input logic [1:0] code);
    thrMv = 14'(base + step * int'(code));
  endfunction

  pcn_shadow_store #(
    .W(pcn_pkg::DATA_W),
    .CYCLES(STORE_CYCLES),
    .FACTORY(CFG_FACTORY)
  ) u_shadow (
    .clk(clk),
    .sys_rst(sys_rst),
    .factoryLoad(factoryLoad),
    .storeStart(s_reg.storeGo),
    .storeData(s_reg.cfg),
    .shadowData(shadowData),
    .busy(storeBusy)
  );

  // Status encoding from the protection conditions
  always_comb begin
    statusBits = 3'h0;
    statusBits[pcn_pkg::STAT_REG_OC_BIT] = regulatorUntuned | overcurrentActive;
    statusBits[pcn_pkg::STAT_UV_BIT] = overdischargeActive;
    if (s_reg.cfg[pcn_pkg::CFG_INHIBIT_OFF_BIT]) begin
      statusBits[pcn_pkg::STAT_CHG_BIT] = overchargeActive;
    end else begin
      statusBits[pcn_pkg::STAT_CHG_BIT] = lowCell | overchargeActive;
    end
  end

  // Sequencing and command handling
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.storeGo = 1'b0;
    case (s_reg.state)
      pcn_pkg::PCN_SLEEP: begin
        // Recall keeps tracking the shadow, so every wake sees the stored copy
        s_next.cfg = shadowData;
        s_next.ctrl = pcn_pkg::CTL_RESET;
        s_next.write_enable_cmd = 1'b0;
        s_next.mux = 3'h0;
        if (wakeDetect) begin
          s_next.state = pcn_pkg::PCN_NORMAL;
        end
      end
      pcn_pkg::PCN_NORMAL: begin
        s_next.mux = link.muxSel;
        if (link.cmdValid && !s_reg.ack) begin
          s_next.ack = 1'b1;
          s_next.rsp = 16'h0000;
          case (link.cmdOp)
            pcn_pkg::PCN_OP_CFG_WR: begin
              s_next.cfg = link.cmdData & pcn_pkg::CFG_USED_MASK;
            end
            pcn_pkg::PCN_OP_CFG_RD: begin
              s_next.rsp = s_reg.cfg;
            end
            pcn_pkg::PCN_OP_CTL_WR: begin
              s_next.ctrl = link.cmdData & pcn_pkg::CTL_USED_MASK;
              if (link.cmdData[pcn_pkg::CTL_SLEEP_BIT]) begin
                s_next.state = pcn_pkg::PCN_SLEEP;
              end
            end
            pcn_pkg::PCN_OP_CTL_RD: begin
              s_next.rsp = s_reg.ctrl;
            end
            pcn_pkg::PCN_OP_STAT_RD: begin
              s_next.rsp = {13'h0000, statusBits};
            end
            pcn_pkg::PCN_OP_WRITE_ENABLE_CMD: begin
              s_next.write_enable_cmd = 1'b1;
            end
            pcn_pkg::PCN_OP_ARRAY_WR: begin
              // Array write without a prior enable is acked and does nothing
              if (s_reg.write_enable_cmd) begin
                s_next.write_enable_cmd = 1'b0;
                s_next.ack = 1'b0;
                // Last answer kept; the response moves only together with an ack
                s_next.rsp = s_reg.rsp;
                s_next.storeGo = 1'b1;
                s_next.state = pcn_pkg::PCN_STORE;
              end
            end
            default: begin
            end
          endcase
        end
      end
      pcn_pkg::PCN_STORE: begin
        // Ack held back until the shadow has committed
        if (!s_reg.storeGo && !storeBusy) begin
          s_next.ack = 1'b1;
          s_next.state = pcn_pkg::PCN_NORMAL;
        end
      end
      default: begin
        s_next.state = pcn_pkg::PCN_SLEEP;
      end
    endcase
  end

  // Power-up lands in sleep with control cleared
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '{state: pcn_pkg::PCN_SLEEP, cfg: 16'h0000, ctrl: pcn_pkg::CTL_RESET,
                 write_enable_cmd: 1'b0, storeGo: 1'b0, ack: 1'b0, rsp: 16'h0000, mux: 3'h0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Link answers
  assign link.deviceAwake = (s_reg.state != pcn_pkg::PCN_SLEEP);
  assign link.cmdAck = s_reg.ack;
  assign link.rspData = s_reg.rsp;

  // Pin drive from the control bits and the registered link mux select; a one switches the FET on
  assign chargeFetOn = s_reg.ctrl[pcn_pkg::CTL_CHG_FET_BIT];
  assign dischargeFetOn = s_reg.ctrl[pcn_pkg::CTL_DSG_FET_BIT];
  assign cellBalanceOn = s_reg.ctrl[pcn_pkg::CTL_BAL_LSB +: 4];
  assign senseGain = s_reg.ctrl[pcn_pkg::CTL_GAIN_LSB +: 2];
  assign analogMuxSel = s_reg.mux;

  // Threshold selections for the analog comparators
  assign fourCells = s_reg.cfg[pcn_pkg::CFG_CELLS_BIT];
  assign lowCellInhibitEn = ~s_reg.cfg[pcn_pkg::CFG_INHIBIT_OFF_BIT];
  assign overchargeMv = thrMv(pcn_pkg::OV_BASE_MV, pcn_pkg::OV_STEP_MV,
                              cfgField(s_reg.cfg, pcn_pkg::CFG_OV_LSB));
  assign undervoltageMv = thrMv(UV_BASE, pcn_pkg::UV_STEP_MV,
                                cfgField(s_reg.cfg, pcn_pkg::CFG_UV_LSB));
  assign overcurrentMv = thrMv(pcn_pkg::OC_BASE_MV, pcn_pkg::OC_STEP_MV,
                               cfgField(s_reg.cfg, pcn_pkg::CFG_OC_LSB));
  assign chargeEnableMv = thrMv(pcn_pkg::CE_BASE_MV, pcn_pkg::CE_STEP_MV,
                                cfgField(s_reg.cfg, pcn_pkg::CFG_CE_LSB));
  assign wakeThresholdMv = 14'(WAKE_MV);
  assign configValue = s_reg.cfg;
endmodule

/* File: logic/pcn_host.sv */
// Pack controller end: APB slave registers that launch link commands,
// keep the link quiet until wake, and gate FET turn-on behind calibration.
// Assumes an APB master on the software side and pcn_device on the link.
`timescale 1ns/10ps
module pcn_host #(
  parameter bit FOUR_CELL = 1'b1,
  parameter int OV_DELAY_MS = 1000,
  parameter int UV_DELAY_MS = 1000,
  parameter int CAL_CYCLES =
    ((OV_DELAY_MS > UV_DELAY_MS ? OV_DELAY_MS : UV_DELAY_MS) + pcn_pkg::CAL_EXTRA_MS)
    * pcn_pkg::CLK_KHZ
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pcn_link_if.host link
);
  generate
    if (CAL_CYCLES < 1) begin : g_bad
      $error("pcn_host: CAL_CYCLES must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic valid;
    logic [2:0] op;
    logic [15:0] data;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [2:0] mux;
    logic [31:0] calCnt;
    logic calDone;
    logic refused;
  } pcn_host_st_t;

  pcn_host_st_t s_reg;
  pcn_host_st_t s_next;
  logic apbWr;
  logic apbRd;
  logic [15:0] launchData;

  // Register select shared by read mux and write decode
  function automatic logic [2:0] regSel(input logic [11:0] addr);
    case (addr)
      pcn_pkg::HOST_CMD_OFS: regSel = 3'h1;
      pcn_pkg::HOST_WDATA_OFS: regSel = 3'h2;
      pcn_pkg::HOST_RDATA_OFS: regSel = 3'h3;
      pcn_pkg::HOST_STATUS_OFS: regSel = 3'h4;
      pcn_pkg::HOST_MUX_OFS: regSel = 3'h5;
      default: regSel = 3'h0;
    endcase
  endfunction

  assign apbWr = psel & penable & pwrite;
  assign apbRd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (regSel(paddr) == 3'h0);

  // FET bits stripped before calibration ends; cell bit forced low on three-cell packs
  always_comb begin
    launchData = s_reg.wdata;
    if (pwdata[2:0] == pcn_pkg::PCN_OP_CTL_WR && !s_reg.calDone) begin
      launchData[pcn_pkg::CTL_CHG_FET_BIT] = 1'b0;
      launchData[pcn_pkg::CTL_DSG_FET_BIT] = 1'b0;
    end
    if (pwdata[2:0] == pcn_pkg::PCN_OP_CFG_WR && !FOUR_CELL) begin
      launchData[pcn_pkg::CFG_CELLS_BIT] = 1'b0;
    end
  end

  // Register writes, command launch and link completion
  always_comb begin
    s_next = s_reg;
    if (apbWr && regSel(paddr) == 3'h4 && pwdata[pcn_pkg::HST_REFUSED_BIT]) begin
      s_next.refused = 1'b0;
    end
    if (apbWr && regSel(paddr) == 3'h2) begin
      s_next.wdata = pwdata[15:0];
    end
    if (apbWr && regSel(paddr) == 3'h5) begin
      s_next.mux = pwdata[2:0];
    end
    if (apbWr && regSel(paddr) == 3'h1 && !s_reg.valid && link.deviceAwake) begin
      s_next.valid = 1'b1;
      s_next.op = pwdata[2:0];
      s_next.data = launchData;
      // Set wins over a clear in the same cycle
      if (launchData != s_reg.wdata) begin
        s_next.refused = 1'b1;
      end
    end
    if (s_reg.valid && link.cmdAck) begin
      s_next.valid = 1'b0;
      s_next.rdata = link.rspData;
    end
    // Calibration timer restarts at every wake; link held low while asleep
    if (!link.deviceAwake) begin
      s_next.valid = 1'b0;
      s_next.op = 3'h0;
      s_next.data = 16'h0000;
      s_next.mux = 3'h0;
      s_next.calCnt = 32'h0000_0000;
      s_next.calDone = 1'b0;
    end else if (!s_reg.calDone) begin
      if (s_reg.calCnt == 32'(CAL_CYCLES - 1)) begin
        s_next.calDone = 1'b1;
      end else begin
        s_next.calCnt = s_reg.calCnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Read mux; reads have no side effects
  always_comb begin
    prdata = 32'h0000_0000;
    if (apbRd) begin
      case (regSel(paddr))
        3'h1: prdata = {29'h0000_0000, s_reg.op};
        3'h2: prdata = {16'h0000, s_reg.wdata};
        3'h3: prdata = {16'h0000, s_reg.rdata};
        3'h4: prdata = {28'h000_0000, s_reg.refused, s_reg.calDone, link.deviceAwake,
                        s_reg.valid};
        3'h5: prdata = {29'h0000_0000, s_reg.mux};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  assign link.cmdValid = s_reg.valid;
  assign link.cmdOp = s_reg.op;
  assign link.cmdData = s_reg.data;
  assign link.muxSel = s_reg.mux;
endmodule

/* File: verif/pcn_link_asserts.sv */
// Checker for the link between pack controller and protection device.
// Assumes plain copies of the link signals and one synchronous reset.
`timescale 1ns/10ps
module pcn_link_asserts #(
  parameter int CAL_CYCLES = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic deviceAwake,
  input wire logic cmdValid,
  input wire logic [2:0] cmdOp,
  input wire logic [15:0] cmdData,
  input wire logic [2:0] muxSel,
  input wire logic cmdAck,
  input wire logic [15:0] rspData
);
  int calCnt;

  // Cycles awake, saturating; restarts on every sleep
  always_ff @(posedge clk) begin
    if (sys_rst || !deviceAwake) calCnt <= 0;
    else if (calCnt < CAL_CYCLES) calCnt <= calCnt + 1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_ack_pulse; cmdAck |=> !cmdAck; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held past one cycle");
  property p_ack_cause; cmdAck |-> cmdValid; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_valid_hold;
    cmdValid && !cmdAck |=> cmdValid && $stable(cmdOp) && $stable(cmdData);
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("request changed before ack");
  property p_valid_drop; cmdAck |=> !cmdValid; endproperty
  a_valid_drop: assert property (p_valid_drop) else $error("request kept after ack");
  property p_ack_bound; $rose(cmdValid) |-> ##[1:40] cmdAck; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("no ack in time");
  property p_quiet; !deviceAwake && !$past(deviceAwake) |-> muxSel == 3'h0 && !cmdValid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("link not quiet in sleep");
  property p_no_ack_sleep; !deviceAwake && !$past(deviceAwake) |-> !cmdAck; endproperty
  a_no_ack_sleep: assert property (p_no_ack_sleep) else $error("ack while asleep");
  property p_rsp_hold; !cmdAck |-> $stable(rspData); endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("response moved without ack");
  // Margin of two cycles below CAL_CYCLES; host and checker start their counts on the same edge
  property p_fet_cal;
    cmdValid && cmdOp == 3'h3 && calCnt < CAL_CYCLES - 2 |-> cmdData[11:10] == 2'b00;
  endproperty
  a_fet_cal: assert property (p_fet_cal) else $error("FET on during calibration");
endmodule

/* File: verif/protection_config_nvram_bench.sv */
// Bench for both ends of the protection config link, joined back to back.
// Assumes pcn_pkg, pcn_link_if, pcn_host and pcn_device are compiled first.
`timescale 1ns/10ps
module protection_config_nvram_bench;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, lastErr;
  logic factoryLoad, wakeDetect, untuned, overcur, overdis, overchg, lowCell;
  logic chgFet, dsgFet, fourCells, inhEn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] bal;
  logic [1:0] gain;
  logic [2:0] amux;
  logic [13:0] ovMv, uvMv, ocMv, ceMv, wakeMv;
  logic [15:0] cfgVal;
  int nFail = 0;
  int numChecks = 0;

  pcn_link_if link();
  pcn_device #(.FOUR_CELL(1'b1), .STORE_CYCLES(3)) pcn_device_inst (
    .clk(clk), .sys_rst(sys_rst), .factoryLoad(factoryLoad), .wakeDetect(wakeDetect),
    .regulatorUntuned(untuned), .overcurrentActive(overcur),
    .overdischargeActive(overdis), .overchargeActive(overchg), .lowCell(lowCell),
    .link(link), .chargeFetOn(chgFet), .dischargeFetOn(dsgFet), .cellBalanceOn(bal),
    .senseGain(gain), .analogMuxSel(amux), .fourCells(fourCells),
    .lowCellInhibitEn(inhEn), .overchargeMv(ovMv), .undervoltageMv(uvMv),
    .overcurrentMv(ocMv), .chargeEnableMv(ceMv), .wakeThresholdMv(wakeMv),
    .configValue(cfgVal));
  pcn_host #(.FOUR_CELL(1'b1), .CAL_CYCLES(20)) pcn_host_inst (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  pcn_link_asserts #(.CAL_CYCLES(20)) pcn_link_asserts_inst (
    .clk(clk), .sys_rst(sys_rst), .deviceAwake(link.deviceAwake),
    .cmdValid(link.cmdValid), .cmdOp(link.cmdOp), .cmdData(link.cmdData),
    .muxSel(link.muxSel), .cmdAck(link.cmdAck), .rspData(link.rspData));

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic testDone();
    if (nFail == 0 && numChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready timeout", 32'h0, 32'h1);
      testDone();
    end
  endtask

  // Poll a status bit, bounded so a hang ends the run
  task automatic stat(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, pcn_pkg::HOST_STATUS_OFS, 32'h0);
      n++;
    end while (rd[b] !== v && n < 200);
    if (rd[b] !== v) begin
      chk("status wait", rd[b], v);
      testDone();
    end
  endtask

  task automatic cmd(input logic [2:0] op, input logic [15:0] d);
    apb(1'b1, pcn_pkg::HOST_WDATA_OFS, {16'h0000, d});
    apb(1'b1, pcn_pkg::HOST_CMD_OFS, {29'h0, op});
    stat(0, 1'b0);
    apb(1'b0, pcn_pkg::HOST_RDATA_OFS, 32'h0);
  endtask

  // Power loss: both ends reset, wake voltage still present
  task automatic pwrCycle();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    stat(1, 1'b1);
  endtask

  task automatic tWake();
    repeat (20) @(posedge clk);
    apb(1'b0, pcn_pkg::HOST_STATUS_OFS, 32'h0);
    chk("awake early", rd[1], 1'b0);
    apb(1'b1, pcn_pkg::HOST_CMD_OFS, 32'h3);
    // A launch would show only after the access edge
    repeat (2) @(posedge clk);
    chk("link asleep", link.cmdValid, 1'b0);
    chk("mux asleep", amux, 3'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", lastErr, 1'b1);
    wakeDetect <= 1'b1;
    stat(1, 1'b1);
    chk("cfg default", cfgVal, 16'h30C0);
    chk("wake mv", wakeMv, 14'h3E80);
    chk("fets off", {dsgFet, chgFet}, 2'b00);
  endtask

  task automatic tFet();
    cmd(3'h3, 16'h0C00);
    chk("fets in cal", {dsgFet, chgFet}, 2'b00);
    apb(1'b0, pcn_pkg::HOST_STATUS_OFS, 32'h0);
    chk("refused", rd[3], 1'b1);
    apb(1'b1, pcn_pkg::HOST_STATUS_OFS, 32'h8);
    apb(1'b0, pcn_pkg::HOST_STATUS_OFS, 32'h0);
    chk("refused clr", rd[3], 1'b0);
    stat(2, 1'b1);
    cmd(3'h3, 16'h0C00);
    chk("fets on", {dsgFet, chgFet}, 2'b11);
    cmd(3'h3, 16'h5645);
    chk("chg only", {dsgFet, chgFet}, 2'b01);
    chk("bal gain", {bal, gain}, 6'h16);
    cmd(3'h7, 16'h0000);
    chk("ctl read", rd[15:0], 16'h5600);
  endtask

  task automatic tSleep();
    apb(1'b1, pcn_pkg::HOST_MUX_OFS, 32'h5);
    apb(1'b0, pcn_pkg::HOST_MUX_OFS, 32'h0);
    chk("mux reg", rd, 32'h5);
    repeat (3) @(posedge clk);
    chk("mux", amux, 3'h5);
    wakeDetect <= 1'b0;
    cmd(3'h3, 16'h0C80);
    stat(1, 1'b0);
    chk("mux sleep", amux, 3'h0);
    wakeDetect <= 1'b1;
    stat(1, 1'b1);
    chk("fets rewake", {dsgFet, chgFet}, 2'b00);
    chk("bal rewake", {bal, gain}, 6'h00);
  endtask

  // Every code of every field, cell and inhibit bits varied alongside
  task automatic tFields();
    logic [15:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {{4{c[1:0]}}, c[0], c[1], 6'h3F};
      cmd(3'h1, v);
      chk("cfg", cfgVal, v & 16'hFFC0);
      chk("ov mv", ovMv, 32'(4200 + 50 * c));
      chk("uv mv", uvMv, 32'(1950 + 100 * c));
      chk("oc mv", ocMv, 32'(75 + 25 * c));
      chk("ce mv", ceMv, 32'(500 + 300 * c));
      chk("cells", fourCells, c[0]);
      chk("inhibit", inhEn, !c[1]);
      cmd(3'h2, 16'h0000);
      chk("cfg read", rd[15:0], v & 16'hFFC0);
    end
  endtask

  task automatic tStatus();
    logic inh;
    for (int i = 0; i < 32; i++) begin
      inh = i[4];
      if (i % 16 == 0) cmd(3'h1, {8'h30, 1'b1, inh, 6'h00});
      untuned <= i[0];
      overcur <= i[1];
      lowCell <= i[2];
      overchg <= i[3];
      overdis <= i[1] ^ i[2];
      cmd(3'h4, 16'h0000);
      chk("stat b0", rd[0], i[0] | i[1]);
      chk("stat b1", rd[1], i[1] ^ i[2]);
      chk("stat b2", rd[2], i[3] | (i[2] & ~inh));
    end
  endtask

  task automatic tStore();
    cmd(3'h1, 16'h5580);
    pwrCycle();
    chk("no store", cfgVal, 16'h30C0);
    cmd(3'h1, 16'h5580);
    cmd(3'h5, 16'h0000);
    cmd(3'h6, 16'h00A5);
    pwrCycle();
    chk("stored", cfgVal, 16'h5580);
    cmd(3'h1, 16'hC0C0);
    cmd(3'h6, 16'h0000);
    pwrCycle();
    chk("no write_enable_cmd", cfgVal, 16'h5580);
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    factoryLoad = 1'b1;
    wakeDetect = 1'b0;
    untuned = 1'b0;
    overcur = 1'b0;
    overdis = 1'b0;
    overchg = 1'b0;
    lowCell = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    factoryLoad <= 1'b0;
    tWake();
    tFet();
    tSleep();
    tFields();
    tStatus();
    tStore();
    testDone();
  end
endmodule
